// [lcd_ctrl_host_bus_port.sv]
/*
  lcd_ctrl_host_bus_port: parallel host port of the character display
  controller, 8 or 4 bit wide, with busy flag and address counter readback.
  Assumes the display core supplies busy, address counter and read data on
  core_clk, and takes the one-cycle write pulses; the serial link is outside.
  Assumes the pads resolve each data line from busPinOe line by line, and that
  every host pin may change at any time relative to core_clk.
  nibbleMode comes from core_clk logic and only changes while the bus is idle.
  Limitation: the read source and busy flag are latched at each read strobe rise,
  so a counter change inside an open strobe shows on the next read only.
  sleepReset is shown in the same cycle that the port goes quiet.
*/
`timescale 1ns/1ns
`default_nettype none
// Operation
// - choice low: write instruction, read busy+counter
// - choice high: data register both ways
// - direction high reads, low writes
// - act on strobe falling edge
// - 4-bit: only upper nibble lines used
// - drive bus only during reads
// - top data line shows busy flag
// - serial sub-address from data line 3
// - sleep low normal, high powers down
// - busy high rejects instructions
// - counter on data lines 6 to 0
// - sleep resets whole state (writeByte and sub_q are not reset)
module lcd_ctrl_host_bus_port
  import lhp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       nibbleMode,
  input  wire logic       strobePin,
  input  wire logic       regChoicePin,
  input  wire logic       readDirPin,
  input  wire logic       sleepPin,
  input  wire logic [7:0] busPinIn,
  output logic      [7:0] busPinOut,
  output logic      [7:0] busPinOe,
  output logic            i2cSubAddr,
  input  wire logic       coreBusy,
  input  wire logic [6:0] coreAddrCount,
  input  wire logic [7:0] coreReadData,
  output logic            instrWrite,
  output logic            dataWrite,
  output logic            dataRead,
  output logic      [7:0] writeByte,
  output logic            instrRejected,
  output logic            sleepReset
);
  lhp_pin_if pins ();

  lhp_pin_sync u_sync (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .strobePin    (strobePin),
    .regChoicePin (regChoicePin),
    .readDirPin   (readDirPin),
    .sleepPin     (sleepPin),
    .busPin       (busPinIn),
    .pins         (pins)
  );

  lhp_state_t state_q;
  logic       strobe_q;
  logic       strobeFall;
  logic       strobeRise;
  logic       lowHalf_q;
  logic [3:0] upperNib_q;
  logic [7:0] readByte_q;
  logic [7:0] driveByte;
  logic       sub_q;
  logic       byteDone;
  logic [7:0] fullByte;
  logic [7:0] statusByte;
  logic       driveOn;
  logic       wrDone;
  logic       rdDone;
  logic       sleepOut_q;

  // the status byte puts the busy flag above the counter; refuse a layout that breaks that
  if (LHP_AC_W + 1 != LHP_BUS_W || LHP_TOP_BIT != LHP_BUS_W - 1 || LHP_SUB_ADDR_BIT >= LHP_BUS_W) begin : g_bad_layout
    $error("status byte layout does not fit the data lines");
  end

  // edges come from the second sync stage only, so a metastable first stage is never read
  assign strobeFall = strobe_q & ~pins.strobe;
  assign strobeRise = ~strobe_q & pins.strobe;
  assign statusByte = {coreBusy, coreAddrCount};

  // sleep acts as a synchronous reset of the port state except writeByte and sub_q
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) strobe_q <= 1'b0;
    else if (pins.sleep) strobe_q <= 1'b0;
    else strobe_q <= pins.strobe;
  end

  // the state keeps the direction seen at the rise for the whole strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) state_q <= LHP_ST_IDLE;
    else if (pins.sleep) state_q <= LHP_ST_IDLE;
    else begin
      unique case (state_q)
        LHP_ST_IDLE: begin
          if (strobeRise) state_q <= (pins.readDir == LHP_DIR_READ) ? LHP_ST_READ : LHP_ST_WRITE;
        end
        LHP_ST_WRITE,
        LHP_ST_READ: begin
          if (strobeFall) state_q <= LHP_ST_IDLE;
        end
        default: state_q <= LHP_ST_IDLE;
      endcase
    end
  end

  // read byte is latched when the strobe rises so it stays steady while driven
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) readByte_q <= LHP_BYTE_RST;
    else if (pins.sleep) readByte_q <= LHP_BYTE_RST;
    else if (strobeRise && pins.readDir == LHP_DIR_READ) begin
      if (pins.regChoice == LHP_CHOICE_CTRL) readByte_q <= statusByte;
      else readByte_q <= coreReadData;
    end
  end

  // nibble phase: toggles on every completed strobe in 4-bit mode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) lowHalf_q <= 1'b0;
    else if (pins.sleep || !nibbleMode) lowHalf_q <= 1'b0;
    else if (strobeFall && state_q != LHP_ST_IDLE) lowHalf_q <= ~lowHalf_q;
  end

  // the upper half waits here for its partner strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) upperNib_q <= LHP_NIB_RST;
    else if (pins.sleep) upperNib_q <= LHP_NIB_RST;
    else if (strobeFall && state_q == LHP_ST_WRITE && nibbleMode && !lowHalf_q)
      upperNib_q <= pins.busIn[7:4];
  end

  assign byteDone = strobeFall && state_q != LHP_ST_IDLE && (!nibbleMode || lowHalf_q);
  // in 4-bit mode the held upper half meets the lower half on the second fall
  assign fullByte = nibbleMode ? {upperNib_q, pins.busIn[7:4]} : pins.busIn;
  assign wrDone   = !pins.sleep && byteDone && state_q == LHP_ST_WRITE;
  assign rdDone   = !pins.sleep && byteDone && state_q == LHP_ST_READ;

  // the written byte holds until the next completed write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) writeByte <= LHP_BYTE_RST;
    else if (wrDone) writeByte <= fullByte;
  end

  // choice is taken at the fall, where the host still holds it steady
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      instrWrite    <= 1'b0;
      dataWrite     <= 1'b0;
      dataRead      <= 1'b0;
      instrRejected <= 1'b0;
    end else begin
      instrWrite    <= 1'b0;
      dataWrite     <= 1'b0;
      dataRead      <= 1'b0;
      instrRejected <= 1'b0;
      if (wrDone) begin
        if (pins.regChoice == LHP_CHOICE_DATA) dataWrite <= 1'b1;
        else if (coreBusy) instrRejected <= 1'b1;
        else instrWrite <= 1'b1;
      end else if (rdDone && pins.regChoice == LHP_CHOICE_DATA) begin
        dataRead <= 1'b1;
      end
    end
  end

  // the serial sub-address bit follows the shared line 3 level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) sub_q <= 1'b0;
    else sub_q <= pins.busIn[LHP_SUB_ADDR_BIT];
  end
  assign i2cSubAddr = sub_q;

  always_comb begin
    driveByte = readByte_q;
    if (nibbleMode && lowHalf_q) driveByte = {readByte_q[3:0], 4'h0};
  end

  // drive only while a read strobe is open; 4-bit mode leaves the low lines released
  assign driveOn = !pins.sleep && state_q == LHP_ST_READ && pins.strobe;

  // one flop pair per data line
  for (genvar ln = 0; ln < LHP_BUS_W; ln++) begin : g_line
    logic laneUsed;
    assign laneUsed = !nibbleMode || ln >= LHP_BUS_W / 2;

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) busPinOe[ln] <= 1'b0;
      else busPinOe[ln] <= driveOn && laneUsed;
    end

    // a released line reads zero so stale read data never leaks out
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) busPinOut[ln] <= 1'b0;
      else busPinOut[ln] <= driveOn && laneUsed && driveByte[ln];
    end
  end

  // one more stage: sleep is shown only once pulses and drive are already quiet
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) sleepOut_q <= 1'b0;
    else sleepOut_q <= pins.sleep;
  end
  assign sleepReset = sleepOut_q;

endmodule : lcd_ctrl_host_bus_port
`default_nettype wire

// [lhp_host_model.sv]
/*
  lhp_host_model: host processor driving the parallel pins of the port.
  assumes the bench resolves the wire level from both drive enables.
*/
`timescale 1ns/1ns
`default_nettype none
module lhp_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] busPinIn,
  output logic            strobePin,
  output logic            regChoicePin,
  output logic            readDirPin,
  output logic      [7:0] hostBus,
  output logic            hostDrv
);
  initial begin
    // a parallel-only host keeps the serial lines parked, so none are modelled
    strobePin = 1'b0;
    regChoicePin = 1'b1;
    readDirPin = 1'b1;
    hostBus = 8'h00;
    hostDrv = 1'b0;
  end
  // lines held 6 cycles past the fall, above the 2 that the synchroniser needs
  task automatic cyc(input logic rc, input logic rd, input logic [7:0] w, output logic [7:0] r);
    @(posedge core_clk);
    regChoicePin <= rc;
    readDirPin <= rd;
    hostBus <= w;
    hostDrv <= !rd;
    repeat (2) @(posedge core_clk);
    strobePin <= 1'b1;
    repeat (7) @(posedge core_clk);
    r = busPinIn;
    strobePin <= 1'b0;
    repeat (6) @(posedge core_clk);
    hostDrv <= 1'b0;
    readDirPin <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : cyc
endmodule : lhp_host_model
`default_nettype wire

// [lhp_pin_if.sv]
/*
  lhp_pin_if: synchronised host pin levels passed from the pin synchroniser
  to the port logic.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface lhp_pin_if;
  logic       strobe;
  logic       regChoice;
  logic       readDir;
  logic       sleep;
  logic [7:0] busIn;
  modport src (output strobe, output regChoice, output readDir, output sleep, output busIn);
  modport dst (input strobe, input regChoice, input readDir, input sleep, input busIn);
endinterface : lhp_pin_if
`default_nettype wire

// [lhp_pin_sync.sv]
/*
  lhp_pin_sync: two flop synchroniser for every host pin level.
  Assumes pins are asynchronous to core_clk; nothing reads the first stage.
*/
`timescale 1ns/1ns
`default_nettype none
module lhp_pin_sync
  import lhp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       strobePin,
  input  wire logic       regChoicePin,
  input  wire logic       readDirPin,
  input  wire logic       sleepPin,
  input  wire logic [7:0] busPin,
  lhp_pin_if.src          pins
);
  logic [11:0] meta_q;
  logic [11:0] sync_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // pull-ups on the choice, direction and data pins give an idle level of one
      meta_q <= LHP_SYNC_RST;
      sync_q <= LHP_SYNC_RST;
    end else begin
      meta_q <= {busPin, sleepPin, readDirPin, regChoicePin, strobePin};
      sync_q <= meta_q;
    end
  end

  assign pins.strobe    = sync_q[0];
  assign pins.regChoice = sync_q[1];
  assign pins.readDir   = sync_q[2];
  assign pins.sleep     = sync_q[3];
  assign pins.busIn     = sync_q[11:4];
endmodule : lhp_pin_sync
`default_nettype wire

// [lhp_pkg.sv]
/*
  lhp_pkg: constants and types shared by the host bus port of the character
  display controller.
  Assumes a single core clock of 100 MHz; all pins arrive asynchronously.
*/
package lhp_pkg;

  localparam int          LHP_BUS_W       = 8;
  localparam int          LHP_AC_W        = 7;
  localparam int          LHP_TOP_BIT     = 7;
  localparam int          LHP_SUB_ADDR_BIT = 3;
  localparam logic        LHP_CHOICE_CTRL = 1'b0;
  localparam logic        LHP_CHOICE_DATA = 1'b1;
  localparam logic        LHP_DIR_READ    = 1'b1;
  localparam logic        LHP_DIR_WRITE   = 1'b0;
  localparam logic [7:0]  LHP_BYTE_RST    = 8'h00;
  localparam logic [3:0]  LHP_NIB_RST     = 4'h0;
  localparam int          LHP_SYNC_STAGES = 2;
  // idle pin levels: bus, direction and choice pulled high, strobe and sleep low
  localparam logic [11:0] LHP_SYNC_RST    = 12'hff6;

  typedef enum logic [1:0] {
    LHP_ST_IDLE  = 2'b00,
    LHP_ST_WRITE = 2'b01,
    LHP_ST_READ  = 2'b10
  } lhp_state_t;

endpackage : lhp_pkg

// [lhp_port_sva.sv]
/*
  lhp_port_sva: pin level checks on the host port.
  assumes core inputs stay steady through each transfer.
*/
`timescale 1ns/1ns
`default_nettype none
module lhp_port_sva (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       nibbleMode,
  input wire logic       readDirPin,
  input wire logic       regChoicePin,
  input wire logic       sleepPin,
  input wire logic       coreBusy,
  input wire logic [6:0] coreAddrCount,
  input wire logic [7:0] coreReadData,
  input wire logic [7:0] busPinOut,
  input wire logic [7:0] busPinOe,
  input wire logic       instrWrite,
  input wire logic       dataWrite,
  input wire logic       dataRead,
  input wire logic       instrRejected,
  input wire logic       sleepReset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_stat; |busPinOe && !regChoicePin && !nibbleMode; endsequence
  sequence s_up; $rose(sleepPin); endsequence
  chk_oe_width: assert property (|busPinOe |-> busPinOe == (nibbleMode ? 8'hf0 : 8'hff))
    else $error("drive mask wrong");
  chk_oe_read: assert property (|busPinOe |-> readDirPin)
    else $error("bus driven outside a read");
  chk_busy_top: assert property (s_stat |-> busPinOut[7] == coreBusy)
    else $error("top line not busy");
  chk_ac_lines: assert property (s_stat |-> busPinOut[6:0] == coreAddrCount)
    else $error("counter lines wrong");
  chk_data_read: assert property (|busPinOe && regChoicePin && !nibbleMode |-> busPinOut == coreReadData)
    else $error("read data wrong");
  chk_write_dir: assert property (instrWrite || dataWrite |-> !readDirPin)
    else $error("write while reading");
  chk_one_pulse: assert property ($onehot0({instrWrite, dataWrite, dataRead, instrRejected}))
    else $error("two pulses at once");
  chk_busy_drop: assert property (instrWrite |-> !$past(coreBusy))
    else $error("instruction taken while busy");
  chk_sleep_sync: assert property (s_up |-> ##[1:3] sleepReset)
    else $error("sleep not seen");
  chk_sleep_quiet: assert property (sleepReset |-> !(instrWrite || dataWrite) && busPinOe == 8'h00)
    else $error("activity during sleep");
endmodule : lhp_port_sva
`default_nettype wire
bind lcd_ctrl_host_bus_port lhp_port_sva sva (.core_clk, .rstn, .nibbleMode, .readDirPin, .regChoicePin,
  .sleepPin, .coreBusy, .coreAddrCount, .coreReadData, .busPinOut, .busPinOe, .instrWrite, .dataWrite,
  .dataRead, .instrRejected, .sleepReset);

// [tb.sv]
/*
  tb: host model on the pins, bench levels on the core side.
  assumes the port and checker files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lhp_pkg::*;
  logic       core_clk = 1'b0, rstn = 1'b0, nibbleMode = 1'b0, sleepPin = 1'b0, coreBusy = 1'b0;
  logic       strobePin, regChoicePin, readDirPin, hostDrv, i2cSubAddr;
  logic       instrWrite, dataWrite, dataRead, instrRejected, sleepReset;
  logic [6:0] coreAddrCount = 7'h00;
  logic [7:0] coreReadData = 8'h00, hostBus, busPinIn, busPinOut, busPinOe, writeByte, r;
  int         errTotal = 0, numChecks = 0, nIw = 0, nDw = 0, nDr = 0, nRej = 0, b[4];
  always #5 core_clk = ~core_clk;
  // internal pull-ups win on any line nobody drives
  always_comb for (int i = 0; i < 8; i++)
    busPinIn[i] = busPinOe[i] ? busPinOut[i] : hostDrv ? hostBus[i] : 1'b1;
  always @(posedge core_clk) begin
    nIw <= nIw + int'(instrWrite);
    nDw <= nDw + int'(dataWrite);
    nDr <= nDr + int'(dataRead);
    nRej <= nRej + int'(instrRejected);
  end
  lhp_host_model host (.core_clk, .busPinIn, .strobePin, .regChoicePin, .readDirPin, .hostBus, .hostDrv);
  lcd_ctrl_host_bus_port uut (.core_clk, .rstn, .nibbleMode, .strobePin, .regChoicePin, .readDirPin,
    .sleepPin, .busPinIn, .busPinOut, .busPinOe, .i2cSubAddr, .coreBusy, .coreAddrCount, .coreReadData,
    .instrWrite, .dataWrite, .dataRead, .writeByte, .instrRejected, .sleepReset);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cnt(input int iw, input int dw, input int dr, input int rj);
    chk(8'(nIw - b[0]), 8'(iw));
    chk(8'(nDw - b[1]), 8'(dw));
    chk(8'(nDr - b[2]), 8'(dr));
    chk(8'(nRej - b[3]), 8'(rj));
    b = '{nIw, nDw, nDr, nRej};
  endtask : cnt
  task automatic t_write;
    host.cyc(1'b0, 1'b0, 8'ha5, r);
    cnt(1, 0, 0, 0);
    chk(writeByte, 8'ha5);
    host.cyc(1'b1, 1'b0, 8'h5a, r);
    cnt(0, 1, 0, 0);
    chk(writeByte, 8'h5a);
  endtask : t_write
  task automatic t_reads;
    @(posedge core_clk);
    coreBusy <= 1'b1;
    coreAddrCount <= 7'h2b;
    coreReadData <= 8'hc3;
    host.cyc(1'b0, 1'b1, 8'h00, r);
    chk(r, 8'hab);
    chk(busPinOe, 8'h00);
    host.cyc(1'b0, 1'b0, 8'h01, r);
    cnt(0, 0, 0, 1);
    coreBusy <= 1'b0;
    host.cyc(1'b1, 1'b1, 8'h00, r);
    chk(r, 8'hc3);
    cnt(0, 0, 1, 0);
  endtask : t_reads
  task automatic t_nibble;
    @(posedge core_clk) nibbleMode <= 1'b1;
    host.cyc(1'b1, 1'b0, 8'h70, r);
    cnt(0, 0, 0, 0);
    host.cyc(1'b1, 1'b0, 8'he0, r);
    cnt(0, 1, 0, 0);
    chk(writeByte, 8'h7e);
    host.cyc(1'b1, 1'b1, 8'h00, r);
    chk(r, 8'hcf);
    host.cyc(1'b1, 1'b1, 8'h00, r);
    chk(r, 8'h3f);
    cnt(0, 0, 1, 0);
    @(posedge core_clk) nibbleMode <= 1'b0;
  endtask : t_nibble
  task automatic t_sleep;
    @(posedge core_clk) sleepPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({7'h00, sleepReset}, 8'h01);
    chk({7'h00, i2cSubAddr}, 8'h01);
    host.cyc(1'b1, 1'b0, 8'h11, r);
    cnt(0, 0, 0, 0);
    sleepPin <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({7'h00, sleepReset}, 8'h00);
  endtask : t_sleep
  task automatic results;
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    b = '{0, 0, 0, 0};
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_write();
    t_reads();
    t_nibble();
    t_sleep();
    results();
  end
  initial begin
    #100000;
    errTotal++;
    results();
  end
endmodule : tb
`default_nettype wire
